// file: design/pwm_regs_map.svh
// Register map constants for the channel count and mirror register bank.
// Assumes an 8-bit register port with a 5-bit byte address.
`ifndef PWM_REGS_MAP_SVH
`define PWM_REGS_MAP_SVH

// Address and data widths of the register port
`define REG_ADDR_W      5
`define REG_DATA_W      8

// Each channel owns a group of four byte addresses starting at channel * 4
`define CH_GROUP_SHIFT  2
`define SLOT_OFS_LOW    2'h0
`define SLOT_CNT_HIGH   2'h1
`define SLOT_CNT_LOW    2'h2

// Shared mirror registers
`define ADDR_RUN_MIR    5'h18
`define ADDR_RELOAD_MIR 5'h19
`define ADDR_LEVEL_MIR  5'h1a

// Reset value of every mirror bit and the read value of unmapped space
`define MIRROR_RESET    1'b0
`define READ_ZERO       8'h00

// Counter byte split
`define CNT_HIGH_MSB    15
`define CNT_HIGH_LSB    8
`define CNT_LOW_MSB     7
`define CNT_STEP        16'h0001

// Most channels whose mirror bits fit below the unimplemented upper bits
`define MAX_CHANNELS    5

`endif

// file: design/pwm_regs_pkg.sv
// Types shared by the channel count and mirror register bank.
// Assumes the map header is compiled alongside.
package pwm_regs_pkg;

	// One register port request, sampled on the rising clock edge
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Per-channel data held in this bank
	typedef struct packed {
		logic [7:0]  phase_shift_low;
		logic [15:0] channel_counter;
	} chan_data_s;

endpackage

// file: design/pwm_count_and_mirror_regs.sv
// Offset low byte, timer counter bytes and shared mirror bits of a multi-channel PWM.
// Assumes one synchronous clock domain, a single-cycle register port and a
// waveform engine outside that supplies count ticks, reload completion and pin levels.
//
// How it works
// - Each channel keeps a read/write low byte of its offset compare value.
// - Each channel's counter high byte is readable and writable by software.
// - Each channel's counter low byte is readable and writable by software.
// - Run mirror low bits are the very storage of each channel's enable bit.
// - Reload mirror low bits are the very storage of each channel's load-arm bit.
// - Mirror bits above the low NUM_CH bits read zero and ignore writes.
// - Level mirror low bits are the very storage of each channel's output bit.
`timescale 1ns/1ps
`include "pwm_regs_map.svh"

module pwm_count_and_mirror_regs #(
	parameter int NUM_CH = 3 // Number of PWM channels
) (
	input  wire logic                               i_clk_sys,     // System clock, 40 MHz
	input  wire logic                               i_srst,        // Synchronous reset, high
	input  wire pwm_regs_pkg::reg_req_s             i_req,         // Register port request
	output logic [7:0]                              o_rdata,       // Read data, cycle after read
	input  wire logic [NUM_CH-1:0]                  i_count_tick,  // Per-channel count enable pulse
	input  wire logic [NUM_CH-1:0]                  i_reload_done, // Reload taken, clears arm
	input  wire logic [NUM_CH-1:0]                  i_level_upd,   // Engine updates pin level
	input  wire logic [NUM_CH-1:0]                  i_level_val,   // New pin level value
	output logic [NUM_CH-1:0]                       o_run,         // Channel enable bits
	output logic [NUM_CH-1:0]                       o_reload_arm,  // Channel load-arm bits
	output logic [NUM_CH-1:0]                       o_pin_level,   // Channel output state bits
	output pwm_regs_pkg::chan_data_s [NUM_CH-1:0]   o_chan_data    // Offset low and counters
);
	import pwm_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// Mirror bits must all fit below the unimplemented upper positions
	if (NUM_CH < 1 || NUM_CH > `MAX_CHANNELS)
	begin
		$error("NUM_CH out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State

	chan_data_s [NUM_CH-1:0] data_reg;
	chan_data_s [NUM_CH-1:0] data_next;
	logic [NUM_CH-1:0]       run_reg;
	logic [NUM_CH-1:0]       run_next;
	logic [NUM_CH-1:0]       arm_reg;
	logic [NUM_CH-1:0]       arm_next;
	logic [NUM_CH-1:0]       level_reg;
	logic [NUM_CH-1:0]       level_next;
	logic [7:0]              rdata_reg;
	logic [7:0]              rdata_next;

	// Address decode of the per-channel group
	logic [`REG_ADDR_W-`CH_GROUP_SHIFT-1:0] grp;
	logic [`CH_GROUP_SHIFT-1:0]             slot;

	assign grp  = i_req.addr[`REG_ADDR_W-1:`CH_GROUP_SHIFT];
	assign slot = i_req.addr[`CH_GROUP_SHIFT-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Offset and counter bytes

	// Software writes win over a count tick so a loaded value is never skipped
	always_comb
	begin
		data_next = data_reg;
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			// Counter advances only while its channel is enabled
			if (run_reg[ch] && i_count_tick[ch])
			begin
				data_next[ch].channel_counter = data_reg[ch].channel_counter + `CNT_STEP;
			end
			if (i_req.wr && grp == ch[`REG_ADDR_W-`CH_GROUP_SHIFT-1:0])
			begin
				case (slot)
					`SLOT_OFS_LOW:
					begin
						data_next[ch].phase_shift_low = i_req.wdata;
					end
					`SLOT_CNT_HIGH:
					begin
						data_next[ch].channel_counter[`CNT_HIGH_MSB:`CNT_HIGH_LSB] = i_req.wdata;
					end
					`SLOT_CNT_LOW:
					begin
						data_next[ch].channel_counter[`CNT_LOW_MSB:0] = i_req.wdata;
					end
					default:
					begin
						data_next[ch] = data_next[ch];
					end
				endcase
			end
		end
	end

	// data kept across reset
	// No reset here: these bytes power up unknown and survive a soft reset
	always_ff @(posedge i_clk_sys)
	begin
		data_reg <= data_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mirror bits

	// Only the low channel bits are stored; upper bits have no storage at all
	always_comb
	begin
		run_next   = run_reg;
		arm_next   = arm_reg;
		level_next = level_reg;
		// Hardware clears the arm once the reload is taken
		arm_next   = arm_next & ~i_reload_done;
		// Engine drives the level between software writes
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			if (i_level_upd[ch])
			begin
				level_next[ch] = i_level_val[ch];
			end
		end
		if (i_req.wr)
		begin
			case (i_req.addr)
				`ADDR_RUN_MIR:
				begin
					run_next = i_req.wdata[NUM_CH-1:0];
				end
				// arm storage write
				// A software set in the cycle of a reload still arms the next one
				`ADDR_RELOAD_MIR:
				begin
					arm_next = (arm_reg & ~i_reload_done & i_req.wdata[NUM_CH-1:0])
						| i_req.wdata[NUM_CH-1:0];
				end
				`ADDR_LEVEL_MIR:
				begin
					level_next = i_req.wdata[NUM_CH-1:0];
				end
				default:
				begin
					run_next = run_next;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			run_reg   <= {NUM_CH{`MIRROR_RESET}};
			arm_reg   <= {NUM_CH{`MIRROR_RESET}};
			level_reg <= {NUM_CH{`MIRROR_RESET}};
		end
		else
		begin
			run_reg   <= run_next;
			arm_reg   <= arm_next;
			level_reg <= level_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	// Read data exist only in the cycle after the strobe; zero otherwise
	always_comb
	begin
		rdata_next = `READ_ZERO;
		if (i_req.rd)
		begin
			case (i_req.addr)
				`ADDR_RUN_MIR:
				begin
					rdata_next[NUM_CH-1:0] = run_reg;
				end
				`ADDR_RELOAD_MIR:
				begin
					rdata_next[NUM_CH-1:0] = arm_reg;
				end
				`ADDR_LEVEL_MIR:
				begin
					rdata_next[NUM_CH-1:0] = level_reg;
				end
				default:
				begin
					for (int ch = 0; ch < NUM_CH; ch++)
					begin
						if (grp == ch[`REG_ADDR_W-`CH_GROUP_SHIFT-1:0])
						begin
							case (slot)
								`SLOT_OFS_LOW:
								begin
									rdata_next = data_reg[ch].phase_shift_low;
								end
								`SLOT_CNT_HIGH:
								begin
									rdata_next = data_reg[ch].channel_counter[`CNT_HIGH_MSB:`CNT_HIGH_LSB];
								end
								`SLOT_CNT_LOW:
								begin
									rdata_next = data_reg[ch].channel_counter[`CNT_LOW_MSB:0];
								end
								default:
								begin
									rdata_next = `READ_ZERO;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// Read data register
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			rdata_reg <= `READ_ZERO;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops

	assign o_rdata      = rdata_reg;
	assign o_run        = run_reg;
	assign o_reload_arm = arm_reg;
	assign o_pin_level  = level_reg;
	assign o_chan_data  = data_reg;

endmodule

// file: verif/pwm_regs_props.sv
// Checker for the count and mirror register bank.
// Assumes it sees only the bank's top ports, one clock, high sync reset.
`timescale 1ns/1ps
module pwm_regs_chk #(
	parameter int NUM_CH = 3 // Channels
) (
	input  wire logic                                 i_clk_sys,    // Clock
	input  wire logic                                 i_srst,       // Reset
	input  wire pwm_regs_pkg::reg_req_s               i_req,        // Request
	input  wire logic [7:0]                           o_rdata,      // Read data
	input  wire logic [NUM_CH-1:0]                    o_run,        // Run bits
	input  wire logic [NUM_CH-1:0]                    o_reload_arm, // Arm bits
	input  wire logic [NUM_CH-1:0]                    o_pin_level,  // Level bits
	input  wire pwm_regs_pkg::chan_data_s [NUM_CH-1:0] o_chan_data  // Channel data
);
	import pwm_regs_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	logic [7:0] wd_reg;
	////////////////////////////////////////////////////////////
	// Write data of the last edge, so each write is judged one cycle on
	always_ff @(posedge i_clk_sys)
	begin
		wd_reg <= i_req.wdata;
	end
	property p_ofs; i_req.wr && i_req.addr == 5'h00 |=> o_chan_data[0][23:16] == wd_reg; endproperty
	a_ofs: assert property (p_ofs) else $error("offset low write lost");
	property p_thi; i_req.wr && i_req.addr == 5'h01 |=> o_chan_data[0][15:8] == wd_reg; endproperty
	a_thi: assert property (p_thi) else $error("counter high write lost");
	property p_tlo; i_req.wr && i_req.addr == 5'h02 |=> o_chan_data[0][7:0] == wd_reg; endproperty
	a_tlo: assert property (p_tlo) else $error("counter low write lost");
	property p_run; i_req.wr && i_req.addr == 5'h18 |=> o_run == wd_reg[NUM_CH-1:0]; endproperty
	a_run: assert property (p_run) else $error("run mirror write lost");
	property p_arm;
		i_req.wr && i_req.addr == 5'h19 |=> o_reload_arm == wd_reg[NUM_CH-1:0];
	endproperty
	a_arm: assert property (p_arm) else $error("arm mirror write lost");
	// Upper bits must read zero whatever was written
	property p_mrd; i_req.rd && i_req.addr == 5'h18 |=> o_rdata == 8'($past(o_run)); endproperty
	a_mrd: assert property (p_mrd) else $error("run mirror read wrong");
	property p_lvl; i_req.wr && i_req.addr == 5'h1a |=> o_pin_level == wd_reg[NUM_CH-1:0]; endproperty
	a_lvl: assert property (p_lvl) else $error("level mirror write lost");
	property p_rst; disable iff (1'b0) i_srst |=> !(|{o_run, o_reload_arm, o_pin_level}); endproperty
	a_rst: assert property (p_rst) else $error("mirror bits kept over reset");
endmodule
bind pwm_count_and_mirror_regs pwm_regs_chk #(.NUM_CH(NUM_CH)) i_chk (.i_clk_sys, .i_srst,
	.i_req, .o_rdata, .o_run, .o_reload_arm, .o_pin_level, .o_chan_data);

// file: verif/pwm_count_and_mirror_regs_bench.sv
// Self-checking bench for the count and mirror register bank.
// Assumes three channels; the bench plays register master and engine.
`timescale 1ns/1ps
module pwm_count_and_mirror_regs_bench;
	import pwm_regs_pkg::*;
	logic             i_clk_sys = 1'b0;
	logic             i_srst = 1'b1;
	reg_req_s         i_req = '0;
	logic [2:0]       tick = '0, done = '0, upd = '0, val = '0;
	logic [7:0]       o_rdata;
	logic [2:0]       o_run, o_arm, o_lvl;
	chan_data_s [2:0] cd;
	int               miscompares = 0;
	int               check_count = 0;
	always #12.5 i_clk_sys = ~i_clk_sys;
	pwm_count_and_mirror_regs #(.NUM_CH(3)) i_dut (.i_clk_sys, .i_srst, .i_req, .o_rdata,
		.i_count_tick(tick), .i_reload_done(done), .i_level_upd(upd), .i_level_val(val),
		.o_run, .o_reload_arm(o_arm), .o_pin_level(o_lvl), .o_chan_data(cd));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus cycles: one strobe cycle, read data judged in the cycle after
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_req <= '{1'b1, 1'b0, a, d};
		@(posedge i_clk_sys);
		i_req <= '0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_clk_sys);
		i_req <= '0;
		@(negedge i_clk_sys);
		chk(16'(o_rdata), 16'(e));
	endtask
	// Engine pulses last one cycle, judged once they land
	task automatic engine(input logic [2:0] t, input logic [2:0] d, input logic [2:0] u);
		@(posedge i_clk_sys);
		{tick, done, upd, val} <= {t, d, u, 3'h2};
		@(posedge i_clk_sys);
		{tick, done, upd} <= '0;
		@(negedge i_clk_sys);
	endtask
	////////////////////////////////////////////////////////////
	// mirrors zero after reset
	task automatic t_zero();
		for (int a = 24; a < 27; a++)
			rd(5'(a), 8'h00);
	endtask
	// bytes per channel, gap slot unmapped
	task automatic t_bytes();
		for (int c = 0; c < 3; c++)
		begin
			for (int s = 0; s < 3; s++)
				wr(5'(c * 4 + s), 8'(16 * s + 16 + c));
			wr(5'(c * 4 + 3), 8'hff);
			for (int s = 0; s < 3; s++)
				rd(5'(c * 4 + s), 8'(16 * s + 16 + c));
			rd(5'(c * 4 + 3), 8'h00);
		end
	endtask
	task automatic t_mirror();
		for (int a = 24; a < 27; a++)
		begin
			wr(5'(a), 8'hfd);
			rd(5'(a), 8'h05);
		end
		chk(16'({o_run, o_arm, o_lvl}), 16'h016d);
	endtask
	// carry across bytes, only running channels count
	task automatic t_count();
		wr(5'h01, 8'h00);
		wr(5'h02, 8'hff);
		wr(5'h18, 8'h01);
		engine(3'h7, 3'h0, 3'h0);
		chk(cd[0].channel_counter, 16'h0100);
		chk(cd[1].channel_counter, 16'h2131);
		rd(5'h01, 8'h01);
		rd(5'h02, 8'h00);
	endtask
	// engine and software share one store
	task automatic t_engine();
		wr(5'h19, 8'h07);
		engine(3'h0, 3'h2, 3'h3);
		rd(5'h19, 8'h05);
		rd(5'h1a, 8'h06);
	endtask
	// software write meets an engine pulse on the same edge
	task automatic t_clash();
		@(posedge i_clk_sys);
		i_req <= '{1'b1, 1'b0, 5'h02, 8'h40};
		tick <= 3'h1;
		@(posedge i_clk_sys);
		i_req <= '{1'b1, 1'b0, 5'h19, 8'h04};
		tick <= 3'h0;
		done <= 3'h5;
		@(posedge i_clk_sys);
		i_req <= '0;
		done <= 3'h0;
		@(negedge i_clk_sys);
		chk(cd[0].channel_counter, 16'h0140);
		chk(16'(o_arm), 16'h0004);
	endtask
	task automatic t_keep();
		@(posedge i_clk_sys);
		i_srst <= 1'b1;
		@(posedge i_clk_sys);
		i_srst <= 1'b0;
		t_zero();
		rd(5'h08, 8'h12);
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		t_zero();
		t_bytes();
		t_mirror();
		t_count();
		t_engine();
		t_clash();
		t_keep();
		complete_run();
	end
endmodule
